/* File: rtl/flash_cfg_pkg.sv */
// Shared constants, types and field positions for the flash read-configuration block.
// Assumes each file that uses it imports this package whole in its module header.
package flash_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Data and configuration widths.
  localparam int DQ_W      = 16;     // Width of the data bus and of the config word.
  localparam int LC_W      = 3;      // Width of the latency field.
  localparam int BL_W      = 3;      // Width of the burst-length field.

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of the read configuration word.
  localparam int RM_BIT    = 15;     // Read mode: 0 burst, 1 page.
  localparam int RES14_BIT = 14;     // Reserved, written as zero.
  localparam int LC_HI     = 13;     // Top bit of the latency field.
  localparam int LC_LO     = 11;     // Bottom bit of the latency field.
  localparam int WP_BIT    = 10;     // Wait polarity: 1 active high.
  localparam int DH_BIT    = 9;      // Data hold: 1 two clocks.
  localparam int WD_BIT    = 8;      // Wait lead: 1 one data cycle early.
  localparam int BS_BIT    = 7;      // Burst order: 1 linear.
  localparam int CE_BIT    = 6;      // Clock edge: 1 rising.
  localparam int BW_BIT    = 3;      // Burst wrap disable: 1 no wrap.
  localparam int BL_HI     = 2;      // Top bit of the burst-length field.
  localparam int BL_LO     = 0;      // Bottom bit of the burst-length field.

  ////////////////////////////////////////////////////////////////////////////////
  // Reset value and encodings.
  localparam logic [DQ_W-1:0] CFG_RESET   = 16'hBFCF;  // Every field at its default.
  localparam logic [LC_W-1:0] LC_MIN      = 3'h2;      // Lowest legal latency code.
  localparam logic [LC_W-1:0] LC_MAX      = 3'h7;      // Used for reserved codes too.
  localparam logic [BL_W-1:0] BL_WORDS4   = 3'h1;      // Four-word burst.
  localparam logic [BL_W-1:0] BL_WORDS8   = 3'h2;      // Eight-word burst.
  localparam logic [BL_W-1:0] BL_WORDS16  = 3'h3;      // Sixteen-word burst.
  localparam logic [3:0]      MASK4       = 4'h3;      // Wrap mask for four words.
  localparam logic [3:0]      MASK8       = 4'h7;      // Wrap mask for eight words.
  localparam logic [3:0]      MASK16      = 4'hF;      // Wrap mask for sixteen words.

  ////////////////////////////////////////////////////////////////////////////////
  // Command codes and identifier space.
  localparam logic [7:0]      CMD_CFG_SETUP   = 8'h60; // First cycle of configure.
  localparam logic [7:0]      CMD_CFG_CONFIRM = 8'h03; // Second cycle of configure.
  localparam logic [7:0]      CMD_READ_ID     = 8'h90; // Enter identifier space.
  localparam logic [7:0]      CMD_READ_ARRAY  = 8'hFF; // Back to array reads.
  localparam logic [7:0]      ID_CFG_OFFSET   = 8'h05; // Config word in id space.
  localparam logic [DQ_W-1:0] ID_OTHER_WORD   = 16'h0000; // Arbitrary value, other ids.

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  // Control pins of the bus, all active low except the burst clock.
  typedef struct packed {
    logic ce_n;               // Chip enable.
    logic oe_n;               // Output enable.
    logic we_n;               // Write enable.
    logic address_valid_n;    // Address valid strobe.
    logic burst_clk;          // Burst clock from the host.
  } bus_ctrl_t;

  // Idle levels of the control pins: enables and strobes high, clock low.
  localparam bus_ctrl_t CTRL_IDLE = 5'h1E;

  // States of the burst engine.
  typedef enum logic [1:0] {ST_IDLE, ST_LATENCY, ST_DATA} burst_state_t;

endpackage

/* File: rtl/pin_sync.sv */
// Two-flop synchroniser for a group of pins from outside the clock domain.
// Assumes only the second stage is read by other logic.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1                    // Number of bits synchronised.
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous input and its synchronised copy.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;                  // First stage, read only by the second.

  // Both stages clear to zero under reset and then follow the pins.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync

/* File: rtl/word_fifo.sv */
// Flop-based word FIFO with valid and ready on both sides and a flush input.
// Assumes a single clock; full and empty are registered flags.
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 16,              // Word width.
  parameter int DEPTH = 32,              // Number of words held.
  parameter int AW    = $clog2(DEPTH)    // Pointer width.
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         flush,
  // Filling side.
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side.
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);

  logic [W-1:0] mem_r [DEPTH];           // Word storage.
  logic [AW-1:0] wr_ptr_r;               // Next slot to write.
  logic [AW-1:0] rd_ptr_r;               // Next slot to read.
  logic [AW:0]   count_r;                // Words held.
  logic [AW:0]   count_nxt;              // Words held after this cycle.
  logic          push;                   // A word enters.
  logic          pop;                    // A word leaves.

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data  = mem_r[rd_ptr_r];

  // Pointers and flags; a flush empties the FIFO and wins over traffic.
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_r  <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r  <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_r   <= count_nxt;
      in_ready  <= (count_nxt != (AW+1)'(DEPTH));
      out_valid <= (count_nxt != '0);
    end
  end

  // Storage is written only on an accepted word.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule // word_fifo

/* File: rtl/flash_burst_read_config.sv */
// Read-configuration and burst-read timing logic of a parallel NOR flash.
// Assumes the host drives the bus pins asynchronously to clk, that the burst
// clock runs well below clk, and that the array source answers combinationally.
//
// How it works
// - bit 15 picks burst or page reads
// - latency codes two to seven, default seven
// - first word after programmed latency clocks
// - no wait states inside a word line; outside identifier space the code asserts wait at any due word while the prefetch FIFO is empty
// - bit 10 sets the wait asserted level
// - wait changes only on valid edges
// - wait asserted until data is valid
// - page reads hold wait deasserted
// - wait floats unless both enables low
// - bit 9 holds words one or two clocks
// - bit 8 moves wait release earlier
// - bit 7 linear order, cleared is reserved
// - bit 6 selects the active clock edge
// - bit 3 cleared wraps within burst length
// - bits 2:0 give four, eight, sixteen, continuous
// - configure command loads, identifier offset five reads
`timescale 1ns/1ps
module flash_burst_read_config
  import flash_cfg_pkg::*;
#(
  parameter int ADDR_W     = 24,         // Width of the word address.
  parameter int FIFO_DEPTH = 32          // Words prefetched from the array.
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Bus pins from the host.
  input  wire bus_ctrl_t         ctrl_pins,
  input  wire logic [ADDR_W-1:0] addr_pins,
  input  wire logic [DQ_W-1:0]   dq_in,
  output logic      [DQ_W-1:0]   dq_out,
  output logic                   dq_oe_n,
  output logic                   wait_out,
  output logic                   wait_oe_n,
  // Array source.
  output logic      [ADDR_W-1:0] array_addr,
  output logic                   array_fetch,
  input  wire logic              array_valid,
  input  wire logic [DQ_W-1:0]   array_data,
  output logic                   array_ready,
  // Configuration view.
  output logic      [DQ_W-1:0]   read_config_reg
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection.

  bus_ctrl_t         ctrl_s;             // Control pins after two flops.
  bus_ctrl_t         ctrl_x;             // Synced pins with idle levels flipped to zero.
  logic [ADDR_W-1:0] addr_s;             // Address after two flops.
  logic [DQ_W-1:0]   dq_s;               // Data in after two flops.
  bus_ctrl_t         ctrl_d_r;           // Control pins one cycle later.

  pin_sync #(.W($bits(bus_ctrl_t))) u_sync_ctrl (
    .clk      (clk),
    .rst      (rst),
    .async_in (ctrl_pins ^ CTRL_IDLE),
    .sync_out (ctrl_x)
  );

  // The stages clear to zero, so the pins cross flipped: reset then reads as idle,
  // not as an active bus with a write strobe.
  assign ctrl_s = ctrl_x ^ CTRL_IDLE;

  pin_sync #(.W(ADDR_W + DQ_W)) u_sync_bus (
    .clk      (clk),
    .rst      (rst),
    .async_in ({addr_pins, dq_in}),
    .sync_out ({addr_s, dq_s})
  );

  // Delayed copy of the synchronised pins for edge detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_d_r <= CTRL_IDLE;
    end else begin
      ctrl_d_r <= ctrl_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration fields and decoded views.

  logic [DQ_W-1:0] cfg_r;                // The read configuration word.
  logic            cfg_pending_r;        // Configure setup seen, confirm awaited.
  logic            id_mode_r;            // Reads come from identifier space.

  wire             sync_mode  = ~cfg_r[RM_BIT];
  wire [LC_W-1:0]  lc_field   = cfg_r[LC_HI:LC_LO];
  wire [LC_W-1:0]  lat        = (lc_field < LC_MIN) ? LC_MAX : lc_field;
  wire             wait_hi    = cfg_r[WP_BIT];
  wire             hold_two   = cfg_r[DH_BIT];
  wire             wait_lead  = cfg_r[WD_BIT];
  wire             rise_edge  = cfg_r[CE_BIT];
  wire [BL_W-1:0]  bl_field   = cfg_r[BL_HI:BL_LO];

  // Wrap mask from the burst length; continuous and reserved lengths never wrap.
  wire [3:0] wrap_mask = (bl_field == BL_WORDS4)  ? MASK4  :
                         (bl_field == BL_WORDS8)  ? MASK8  :
                         (bl_field == BL_WORDS16) ? MASK16 : 4'h0;
  // Wrap only when the wrap-disable bit is cleared.
  wire       wrap_on   = ~cfg_r[BW_BIT] & (wrap_mask != 4'h0);

  // Clock and strobe edges seen through the synchronisers.
  wire clk_rise   = ctrl_s.burst_clk & ~ctrl_d_r.burst_clk;
  wire clk_fall   = ~ctrl_s.burst_clk & ctrl_d_r.burst_clk;
  wire valid_edge = rise_edge ? clk_rise : clk_fall;
  wire we_rise    = ctrl_s.we_n & ~ctrl_d_r.we_n;
  wire bus_active = ~ctrl_s.ce_n & ~ctrl_s.oe_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode on the end of each write cycle.

  wire       cmd_write   = we_rise & ~ctrl_s.ce_n;
  wire [7:0] cmd_byte    = dq_s[7:0];
  wire       cfg_load    = cmd_write & cfg_pending_r & (cmd_byte == CMD_CFG_CONFIRM);

  // The config word is taken from the address lines of the confirm cycle;
  // any other second cycle abandons the configure sequence.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r         <= CFG_RESET;
      cfg_pending_r <= 1'b0;
      id_mode_r     <= 1'b0;
    end else if (cmd_write) begin
      if (cfg_pending_r) begin
        cfg_pending_r <= 1'b0;
      end else begin
        cfg_pending_r <= (cmd_byte == CMD_CFG_SETUP);
      end
      if (cfg_load) begin
        cfg_r <= addr_s[DQ_W-1:0];
      end
      if (!cfg_pending_r && cmd_byte == CMD_READ_ID) begin
        id_mode_r <= 1'b1;
      end else if (!cfg_pending_r && cmd_byte == CMD_READ_ARRAY) begin
        id_mode_r <= 1'b0;
      end
    end
  end

  // Identifier space shows the configuration word at its fixed offset.
  wire [DQ_W-1:0] id_word = (addr_s[7:0] == ID_CFG_OFFSET) ? cfg_r : ID_OTHER_WORD;

  ////////////////////////////////////////////////////////////////////////////////
  // Array prefetch into the FIFO.

  logic [ADDR_W-1:0] read_addr_r;        // Address the current read started at.
  logic              fifo_in_ready;      // FIFO can take a word.
  logic              fifo_out_valid;     // FIFO holds a word.
  logic [DQ_W-1:0]   fifo_out_data;      // Head word of the FIFO.
  logic              fifo_pop;           // Head word consumed by the burst.

  // A burst starts on a valid edge while the address strobe is low.
  wire burst_start = sync_mode & ~ctrl_s.ce_n & ~ctrl_s.address_valid_n & valid_edge;
  // A page read restarts the prefetch whenever its address moves.
  wire page_move   = ~sync_mode & ~ctrl_s.ce_n & (addr_s != read_addr_r);
  wire restart     = burst_start | page_move;
  wire fifo_push   = array_valid & array_fetch & ~restart;

  // Next array address, wrapping in the low bits when wrap is on.
  wire [ADDR_W-1:0] addr_inc  = ADDR_W'(array_addr + 1'b1);
  wire [ADDR_W-1:0] addr_wrap = {array_addr[ADDR_W-1:4],
                                 (array_addr[3:0] & ~wrap_mask) |
                                 (addr_inc[3:0] & wrap_mask)};
  wire [ADDR_W-1:0] addr_next = wrap_on ? addr_wrap : addr_inc;

  word_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) u_prefetch (
    .clk       (clk),
    .rst       (rst),
    .flush     (restart),
    .in_valid  (fifo_push),
    .in_data   (array_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop)
  );

  assign array_ready = fifo_in_ready;

  // Prefetch pointer: reloaded on each restart, stepped on each accepted word.
  // Fetching runs only outside identifier space and stops when chip enable rises.
  always_ff @(posedge clk) begin
    if (rst) begin
      array_addr  <= '0;
      array_fetch <= 1'b0;
      read_addr_r <= '0;
    end else if (restart) begin
      array_addr  <= addr_s;
      read_addr_r <= addr_s;
      array_fetch <= ~id_mode_r;
    end else begin
      if (fifo_push && fifo_in_ready) begin
        array_addr <= addr_next;
      end
      if (ctrl_s.ce_n || id_mode_r) begin
        array_fetch <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst engine.

  burst_state_t state_r;                 // Engine state.
  burst_state_t state_nxt;               // Next engine state.
  logic [LC_W:0] lat_cnt_r;              // Valid edges since the burst started.
  logic          phase_r;                // Second clock of a two-clock word.
  logic          wait_asrt_r;            // Wait is asserted, before polarity.

  wire [LC_W:0] lat_cnt_inc = (LC_W+1)'(lat_cnt_r + 1'b1);
  wire [LC_W:0] lead_cnt    = wait_lead ? (hold_two ? (LC_W+1)'(2) : (LC_W+1)'(1))
                                        : '0;
  wire          lat_done    = (state_r == ST_LATENCY) & ~burst_start &
                              (lat_cnt_inc == {1'b0, lat});
  // Edges counted at this edge; the start edge is zero, whatever the old count.
  wire [LC_W:0] edge_cnt    = burst_start ? '0 : lat_cnt_inc;
  // Wait may release early when the first word is one data cycle away.
  wire          lead_done   = (edge_cnt + lead_cnt) >= {1'b0, lat};
  // A word is due at the end of latency or when the hold time has run.
  wire          word_due    = valid_edge & bus_active &
                              (lat_done | ((state_r == ST_DATA) & (~hold_two | phase_r)));
  wire          word_ready  = id_mode_r | fifo_out_valid;
  wire          word_emit   = word_due & word_ready;

  assign fifo_pop = word_emit & ~id_mode_r;

  // Next state: idle without chip enable, latency after a start, data after it.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (burst_start) begin
          state_nxt = ST_LATENCY;
        end
      end
      ST_LATENCY: begin
        if (lat_done && bus_active && valid_edge) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        state_nxt = ST_DATA;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (ctrl_s.ce_n || !sync_mode) begin
      state_nxt = ST_IDLE;
    end else if (burst_start) begin
      state_nxt = ST_LATENCY;
    end
  end

  // Latency counter and hold phase advance only on valid clock edges.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      lat_cnt_r <= '0;
      phase_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (burst_start) begin
        lat_cnt_r <= '0;
        phase_r   <= 1'b0;
      end else if (valid_edge && state_r == ST_LATENCY && bus_active) begin
        lat_cnt_r <= lat_cnt_inc;
      end
      if (word_emit) begin
        phase_r <= 1'b0;
      end else if (valid_edge && state_r == ST_DATA && hold_two && bus_active) begin
        phase_r <= ~phase_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wait tracking: asserted until the next word is on the bus.

  // Wait moves on valid edges of an active cycle in burst mode and clears when deselected or in page mode; once the
  // first word is out it stays released while words keep coming.
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_asrt_r <= 1'b0;
    end else if (!sync_mode || ctrl_s.ce_n) begin
      wait_asrt_r <= 1'b0;
    end else if (valid_edge && bus_active) begin
      if (state_r != ST_DATA && state_nxt != ST_DATA) begin
        wait_asrt_r <= ~lead_done;
      end else if (word_due) begin
        wait_asrt_r <= ~word_ready;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin outputs, all from flops.

  // Data follows the emitted word in burst mode and the address in page mode;
  // the pins are released whenever either enable is high.
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_out    <= '0;
      dq_oe_n   <= 1'b1;
      wait_out  <= 1'b0;
      wait_oe_n <= 1'b1;
    end else begin
      dq_oe_n   <= ~bus_active;
      wait_oe_n <= ~bus_active;
      if (!sync_mode && bus_active) begin
        dq_out <= id_mode_r ? id_word : fifo_out_data;
      end else if (word_emit) begin
        dq_out <= id_mode_r ? id_word : fifo_out_data;
      end
      // Polarity maps the asserted flag onto the pin level.
      if (!sync_mode) begin
        wait_out <= ~wait_hi;
      end else if (!bus_active) begin
        wait_out <= wait_hi;
      end else if (valid_edge) begin
        wait_out <= wait_hi ~^ wait_state_nxt();
      end
    end
  end

  // The asserted flag as it will stand after this valid edge.
  function automatic logic wait_state_nxt();
    logic asrt;
    asrt = wait_asrt_r;
    if (state_r != ST_DATA && state_nxt != ST_DATA) begin
      asrt = ~lead_done;
    end else if (word_due) begin
      asrt = ~word_ready;
    end
    return asrt;
  endfunction

  assign read_config_reg = cfg_r;

endmodule // flash_burst_read_config

/* File: verification/flash_cfg_asserts.sv */
// Concurrent checks on the pins of the flash read-configuration block.
// Assumes pins pass two sync flops and one output register before they act.
`timescale 1ns/1ps
module flash_cfg_asserts
  import flash_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic            clk,
  input wire logic            rst,
  // Watched ports.
  input wire bus_ctrl_t       ctrl_pins,
  input wire logic            dq_oe_n,
  input wire logic            wait_out,
  input wire logic            wait_oe_n,
  input wire logic [DQ_W-1:0] read_config_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Deselected, or both enables active, long enough to cross the synchronisers.
  sequence desel_s; ctrl_pins.ce_n [*4]; endsequence
  sequence active_s; (!ctrl_pins.ce_n && !ctrl_pins.oe_n) [*4]; endsequence
  cfg_reset_a: assert property (disable iff (1'b0) rst |=> read_config_reg == CFG_RESET)
    else $error("config word not at default after reset");
  wait_float_a: assert property (desel_s |-> wait_oe_n)
    else $error("wait driven while deselected");
  wait_drive_a: assert property (active_s |-> !wait_oe_n)
    else $error("wait not driven with both enables low");
  wait_cause_a: assert property (!wait_oe_n |-> !$past(ctrl_pins.ce_n, 3) && !$past(ctrl_pins.oe_n, 3))
    else $error("wait driven without enables");
  data_cause_a: assert property (!dq_oe_n |-> !$past(ctrl_pins.ce_n, 3) && !$past(ctrl_pins.oe_n, 3))
    else $error("data bus driven without enables");
  page_wait_a: assert property (read_config_reg[RM_BIT] && !wait_oe_n && $past(!wait_oe_n)
    |-> wait_out == !read_config_reg[WP_BIT]) else $error("wait asserted in page mode");
  cfg_load_a: assert property ($changed(read_config_reg)
    |-> $past(ctrl_pins.we_n, 3) && !$past(ctrl_pins.we_n, 5)) else $error("config changed without write");
  // A wait change must follow a burst clock edge seen through the synchronisers.
  wait_edge_a: assert property ($changed(wait_out) && !wait_oe_n && $past(!wait_oe_n)
    |-> $past(ctrl_pins.burst_clk, 2) != $past(ctrl_pins.burst_clk, 5)) else $error("wait moved off edge");
endmodule // flash_cfg_asserts
bind flash_burst_read_config flash_cfg_asserts flash_cfg_asserts_inst (.clk(clk), .rst(rst),
  .ctrl_pins(ctrl_pins), .dq_oe_n(dq_oe_n), .wait_out(wait_out), .wait_oe_n(wait_oe_n),
  .read_config_reg(read_config_reg));

/* File: verification/flash_host_model.sv */
// Host-side bus model: enables, command writes and a burst clock.
// Assumes clk is the device clock; the burst clock idles low between frames.
`timescale 1ns/1ps
module flash_host_model
  import flash_cfg_pkg::*;
(
  // Clock.
  input wire logic    clk,
  // Pins toward the device.
  output bus_ctrl_t   ctrl,
  output logic [23:0] addr,
  output logic [15:0] dq
);
  initial begin
    ctrl = CTRL_IDLE;
    addr = '0;
    dq = '0;
  end
  // Waits n clocks, then steps just off the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Sets the select pins and the address.
  task automatic sel(input logic ce, input logic oe, input logic adv, input logic [23:0] a);
    ctrl.ce_n = ce;
    ctrl.oe_n = oe;
    ctrl.address_valid_n = adv;
    addr = a;
  endtask
  // One command cycle; released lines show the inverse of their last value.
  task automatic wr(input logic [7:0] cmd, input logic [23:0] a);
    sel(1'b0, 1'b1, 1'b1, a);
    dq = {8'h00, cmd};
    ctrl.we_n = 1'b0;
    tick(4);
    ctrl.we_n = 1'b1;
    tick(4);
    sel(1'b1, 1'b1, 1'b1, ~a);
    dq = ~dq;
    tick(1);
  endtask
  // One 160 ns burst clock period holding both a rising and a falling edge.
  task automatic bedge();
    ctrl.burst_clk = 1'b1;
    tick(4);
    ctrl.burst_clk = 1'b0;
    tick(4);
  endtask
endmodule // flash_host_model

/* File: verification/flash_burst_read_config_tb.sv */
// Self-checking bench: config loads, page and burst reads, identifier reads.
// Assumes a random-stall array source and the host model on the bus pins.
`timescale 1ns/1ps
module flash_burst_read_config_tb
  import flash_cfg_pkg::*;
;
  logic        clk = 0;
  logic        rst = 1;
  bus_ctrl_t   ctrl;
  logic [23:0] addr;
  logic [23:0] arr_addr;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [15:0] cfg_rd;
  logic        dq_oe_n;
  logic        wait_out;
  logic        wait_oe_n;
  logic        arr_valid = 0;
  logic        arr_fetch;
  logic        arr_ready;
  logic [15:0] arr_data;
  assign arr_data = arr_addr[15:0] ^ 16'h5A3C;
  int          fails = 0;
  int          num_checks = 0;
  always #10 clk = ~clk;
  // The array source stalls about one cycle in four.
  always @(posedge clk) begin
    #1 arr_valid = ($urandom % 4) != 0;
  end
  flash_host_model flash_host_model_inst (.clk(clk), .ctrl(ctrl), .addr(addr), .dq(dq_in));
  flash_burst_read_config flash_burst_read_config_inst (.clk(clk), .rst(rst), .ctrl_pins(ctrl),
    .addr_pins(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wait_out(wait_out),
    .wait_oe_n(wait_oe_n), .array_addr(arr_addr), .array_fetch(arr_fetch),
    .array_valid(arr_valid), .array_data(arr_data), .array_ready(arr_ready),
    .read_config_reg(cfg_rd));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reserved bits zero; linear order, no wrap, continuous length.
  function automatic logic [15:0] mk_cfg(input logic [2:0] lc, input logic [3:0] f);
    return {2'b00, lc, f[0], f[1], f[2], 1'b1, f[3], 2'b00, 1'b1, 3'h7};
  endfunction
  task automatic cfg_write(input logic [15:0] c);
    flash_host_model_inst.wr(CMD_CFG_SETUP, {8'h00, c});
    flash_host_model_inst.wr(CMD_CFG_CONFIRM, {8'h00, c});
  endtask
  // Burst from a: wait, then words held one or two edges.
  task automatic burst(input logic [15:0] c, input logic [23:0] a);
    int lat;
    int hold;
    int lead;
    logic [15:0] m;
    logic [15:0] w;
    lat = int'(c[LC_HI:LC_LO]);
    m = {12'h000, (c[2:0] == BL_WORDS4) ? MASK4 : (c[2:0] == BL_WORDS8) ? MASK8 : MASK16};
    if (c[BW_BIT]) m = 16'hFFFF;
    hold = c[DH_BIT] ? 2 : 1;
    lead = c[WD_BIT] ? hold : 0;
    flash_host_model_inst.sel(1'b0, 1'b0, 1'b0, a);
    flash_host_model_inst.tick(4);
    for (int n = 0; n <= lat + 2 * hold; n++) begin
      flash_host_model_inst.bedge();
      flash_host_model_inst.sel(1'b0, 1'b0, 1'b1, a);
      check("wait", {15'h0, c[WP_BIT] ^ (n >= lat - lead)}, {15'h0, wait_out});
      w = (a[15:0] & ~m) | ((a[15:0] + 16'((n - lat) / hold)) & m);
      if (n >= lat) check("data", w ^ 16'h5A3C, dq_out);
    end
    flash_host_model_inst.sel(1'b1, 1'b1, 1'b1, ~a);
    flash_host_model_inst.tick(4);
  endtask
  initial begin
    logic [15:0] c;
    logic [2:0]  lc;
    logic [31:0] r;
    void'($urandom(32'h25578f8c));
    repeat (8) @(posedge clk);
    #1 rst = 0;
    check("config", CFG_RESET, cfg_rd);
    flash_host_model_inst.sel(1'b0, 1'b0, 1'b1, 24'h000100);
    flash_host_model_inst.tick(8);
    check("wait_page", 16'h0, {15'h0, wait_out});
    check("wait_oe", 16'h0, {15'h0, wait_oe_n});
    check("dq_oe", 16'h0, {15'h0, dq_oe_n});
    flash_host_model_inst.sel(1'b1, 1'b1, 1'b1, 24'hFFFEFF);
    flash_host_model_inst.tick(4);
    check("wait_oe", 16'h1, {15'h0, wait_oe_n});
    for (int i = 0; i < 8; i++) begin
      lc = 3'h2 + 3'($urandom % 6);
      r = $urandom;
      c = mk_cfg(lc, {r[3], r[2] & ~(lc == 3'h2 && r[1]), r[1:0]});
      if (r[4]) c = {c[15:4], 1'b0, BL_WORDS4 + 3'(r[6:5] % 3)};
      if (i == 0) c = mk_cfg(3'h2, 4'h4); // Shortest latency, early wait, falling edge.
      cfg_write(c);
      check("config", c, cfg_rd);
      burst(c, 24'($urandom) & (c[BW_BIT] ? 24'hFFFFFC : 24'hFFFFFF));
    end
    flash_host_model_inst.wr(CMD_CFG_SETUP, 24'h00FFFF);
    flash_host_model_inst.wr(CMD_READ_ARRAY, 24'h00FFFF);
    check("config", c, cfg_rd);
    c = mk_cfg(3'h4, 4'hA) | 16'h8000;
    cfg_write(c);
    flash_host_model_inst.wr(CMD_READ_ID, 24'h0);
    flash_host_model_inst.sel(1'b0, 1'b0, 1'b1, {16'h0, ID_CFG_OFFSET});
    flash_host_model_inst.tick(10);
    check("id_config", c, dq_out);
    check("wait_low", 16'h1, {15'h0, wait_out});
    flash_host_model_inst.sel(1'b0, 1'b0, 1'b1, 24'h000006);
    flash_host_model_inst.tick(10);
    check("id_other", ID_OTHER_WORD, dq_out);
    flash_host_model_inst.sel(1'b1, 1'b1, 1'b1, 24'hFFFFF9);
    flash_host_model_inst.wr(CMD_READ_ARRAY, 24'h0);
    rst = 1;
    flash_host_model_inst.tick(3);
    rst = 0;
    check("config", CFG_RESET, cfg_rd);
    flash_host_model_inst.tick(2);
    check("dq_oe", 16'h1, {15'h0, dq_oe_n});
    check("fetch", 16'h0, {15'h0, arr_fetch});
    check("ready", 16'h1, {15'h0, arr_ready});
    print_verdict();
  end
  // Watchdog well past the expected run length.
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule // flash_burst_read_config_tb
